/* File: src/pan_pkg.sv */
package pan_pkg;
	// Management register addresses
	localparam logic [4:0] ADDR_STATUS = 5'h01;
	localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
	localparam logic [4:0] ADDR_ID_LOW = 5'h03;
	localparam logic [4:0] ADDR_ADV = 5'h04;
	localparam logic [4:0] ADDR_PARTNER = 5'h05;
	// Status word fields
	localparam int STS_EXT_BIT = 0;
	localparam int STS_JABBER_BIT = 1;
	localparam int STS_ABIL_LSB = 11;
	localparam logic [4:0] STS_ABIL_RESET = 5'h0f;
	// Identifier fields
	localparam int ID_HIGH_ORG_LSB = 6;
	localparam int ID_LOW_ORG_LSB = 10;
	localparam int ID_LOW_MODEL_LSB = 4;
	localparam int ID_LOW_REV_LSB = 0;
	// Advertisement fields
	localparam int ADV_NP_BIT = 15;
	localparam int ADV_RSVD14_BIT = 14;
	localparam int ADV_RF_BIT = 13;
	localparam int ADV_RSVD12_BIT = 12;
	localparam int ADV_ASYM_BIT = 11;
	localparam int ADV_PAUSE_BIT = 10;
	localparam int ADV_T4_BIT = 9;
	localparam int ADV_TECH_LSB = 5;
	localparam int ADV_TECH_W = 4;
	localparam logic [15:0] ADV_WR_MASK = 16'h2de0;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;
	// Partner word reset value
	localparam logic [15:0] PARTNER_RESET = 16'h0000;
	// Restart handshake states
	typedef enum logic [2:0] {
		RST_IDLE = 3'b001,
		RST_LOAD = 3'b010,
		RST_DROP = 3'b100
	} pan_restart_t;
endpackage

/* File: src/pan_lp_if.sv */
`timescale 1ns/1ps
interface pan_lp_if;
	logic capture;
	logic [15:0] page_word;
	logic next_page;
	logic clear;
	logic [15:0] lp_word;
	logic lp_is_next;
	modport regs (output capture, output page_word, output next_page, output clear,
		input lp_word, input lp_is_next);
	modport latch (input capture, input page_word, input next_page, input clear,
		output lp_word, output lp_is_next);
endinterface

/* File: src/pan_partner_latch.sv */
`timescale 1ns/1ps
module pan_partner_latch (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	pan_lp_if.latch lp
);
	logic [15:0] word_q;
	logic [15:0] word_d;
	logic next_q;
	logic next_d;

	// Partner code word is held raw; a next page keeps its own layout
	always_comb begin
		word_d = word_q;
		next_d = next_q;
		if (lp.clear) begin
			word_d = pan_pkg::PARTNER_RESET;
			next_d = 1'b0;
		end
		if (lp.capture) begin
			word_d = lp.page_word;
			next_d = lp.next_page;
		end
	end

	// Capture wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_q <= pan_pkg::PARTNER_RESET;
			next_q <= 1'b0;
		end else if (clk_en_i) begin
			word_q <= word_d;
			next_q <= next_d;
		end
	end

	assign lp.lp_word = word_q;
	assign lp.lp_is_next = next_q;
endmodule

/* File: src/pan_regs.sv */
// Operation
// - At 10 Mb/s a jabber event sets a sticky flag, cleared by status read.
// - Status bit 0 always reads one: extended registers exist.
// - Identifier high register is read-only, upper organization identifier bits.
// - Identifier low bits 15:10 hold the low six organization bits.
// - Identifier low bits 9:4 hold a fixed model code.
// - Identifier low bits 3:0 hold a fixed silicon revision code.
// - Advertisement bits 15 and 14 read zero; no next page.
// - Advertisement bit 13 is writable, resets zero, sends remote fault.
// - Technology field resets from status ability bits; management may rewrite it.
// - Advertisement writes store at once, go on the link at restart.
// - Advertisement bit 11 writable, resets zero, asymmetric pause.
// - Advertisement bit 10 writable, resets zero, symmetric pause.
// - Advertisement bits 12 and 9 read zero; four-pair never advertised.
// - Advertisement bits 8 to 5 writable, reset one, speed and duplex.
// - Advertisement bits 4:0 read-only selector, value 00001.
// - Partner bit 15 set when partner requests next page; resets zero.
// - Partner bit 14 set when partner acknowledges three consistent bursts.
// - Partner bit 13 set when partner reports a fault.
// - Partner bits 12:5 hold partner technology abilities.
// - Partner bits 4:0 hold partner selector, reset zero.
// - A received next page keeps the next-page transmit layout.
// - Restart via control bit 9; the device clears it itself.
`timescale 1ns/1ps
module pan_regs #(
	parameter logic [23:0] ORG_ID = 24'h123456, // Arbitrary value
	parameter logic [5:0] MODEL_CODE = 6'h2a, // Arbitrary value
	parameter logic [3:0] REV_CODE = 4'h1, // Arbitrary value
	parameter logic [4:0] STATUS_ABILITY = pan_pkg::STS_ABIL_RESET
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic mgmt_rd_i,
	input wire logic mgmt_wr_i,
	input wire logic [15:0] mgmt_wdata_i,
	output logic [15:0] mgmt_rdata_o,
	output logic mgmt_rvalid_o,
	input wire logic speed_10_i,
	input wire logic jabber_event_i,
	input wire logic autoneg_restart_i,
	output logic autoneg_restart_clr_o,
	output logic [15:0] adv_active_o,
	input wire logic partner_page_valid_i,
	input wire logic [15:0] partner_page_i,
	input wire logic partner_next_page_i,
	output logic partner_is_next_page_o
);
	// Four-pair ability can never be claimed since it is never advertised
	if (STATUS_ABILITY[4] != 1'b0) begin : g_bad_ability
		$error("pan_regs: four-pair ability is not supported");
	end

	// Address match, used by both read and write decode
	function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] reg_addr);
		addr_hit = (addr == reg_addr);
	endfunction

	// Technology field reset comes from status ability bits 14:11
	function automatic logic [15:0] adv_reset_word(input logic [4:0] ability);
		logic [15:0] w;
		w = 16'h0000;
		w[pan_pkg::ADV_TECH_LSB +: pan_pkg::ADV_TECH_W] = ability[3:0];
		w[4:0] = pan_pkg::SELECTOR_8023;
		adv_reset_word = w;
	endfunction

	// Force read-only advertisement bits to their fixed values
	function automatic logic [15:0] adv_fix(input logic [15:0] raw);
		logic [15:0] w;
		w = raw & pan_pkg::ADV_WR_MASK;
		w[pan_pkg::ADV_NP_BIT] = 1'b0;
		w[pan_pkg::ADV_RSVD14_BIT] = 1'b0;
		w[pan_pkg::ADV_RSVD12_BIT] = 1'b0;
		w[pan_pkg::ADV_T4_BIT] = 1'b0;
		w[4:0] = pan_pkg::SELECTOR_8023;
		adv_fix = w;
	endfunction

	localparam logic [15:0] ADV_RESET = adv_reset_word(STATUS_ABILITY);

	// Decoded strobes
	logic rd_status;
	logic wr_adv;
	logic [15:0] status_word;
	logic [15:0] id_high_word;
	logic [15:0] id_low_word;

	assign rd_status = mgmt_rd_i && addr_hit(mgmt_addr_i, pan_pkg::ADDR_STATUS);
	assign wr_adv = mgmt_wr_i && addr_hit(mgmt_addr_i, pan_pkg::ADDR_ADV);

	// ---- Jabber latch
	logic jabber_q;
	logic jabber_d;

	// Set beats the read clear so no event is lost
	always_comb begin
		jabber_d = jabber_q;
		if (rd_status) begin
			jabber_d = 1'b0;
		end
		if (jabber_event_i && speed_10_i) begin
			jabber_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			jabber_q <= 1'b0;
		end else if (clk_en_i) begin
			jabber_q <= jabber_d;
		end
	end

	// ---- Status, identifier words
	always_comb begin
		status_word = 16'h0000;
		// Ability bits are constants, so control writes cannot move them
		status_word[pan_pkg::STS_ABIL_LSB +: 5] = STATUS_ABILITY;
		status_word[pan_pkg::STS_JABBER_BIT] = jabber_q;
		status_word[pan_pkg::STS_EXT_BIT] = 1'b1;
	end

	// Only 16 of the upper 18 identifier bits fit the high word
	assign id_high_word = ORG_ID[21:6];

	always_comb begin
		id_low_word = 16'h0000;
		id_low_word[pan_pkg::ID_LOW_ORG_LSB +: 6] = ORG_ID[5:0];
		id_low_word[pan_pkg::ID_LOW_MODEL_LSB +: 6] = MODEL_CODE;
		id_low_word[pan_pkg::ID_LOW_REV_LSB +: 4] = REV_CODE;
	end

	// ---- Stored advertisement
	logic [15:0] adv_q;
	logic [15:0] adv_d;
	logic [15:0] adv_wr_val;

	// Per-bit merge of writable bits, others held fixed
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_adv_bit
			if (pan_pkg::ADV_WR_MASK[gi]) begin : g_rw
				assign adv_wr_val[gi] = mgmt_wdata_i[gi];
			end else begin : g_ro
				assign adv_wr_val[gi] = adv_q[gi];
			end
		end
	endgenerate

	// Write stores immediately; link sees it only at restart
	always_comb begin
		adv_d = adv_q;
		if (wr_adv) begin
			adv_d = adv_fix(adv_wr_val);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			adv_q <= ADV_RESET;
		end else if (clk_en_i) begin
			adv_q <= adv_d;
		end
	end

	// ---- Restart handshake and active advertisement
	pan_pkg::pan_restart_t rs_q;
	pan_pkg::pan_restart_t rs_d;
	logic [15:0] active_q;
	logic [15:0] active_d;
	logic clr_d;
	logic clr_q;

	// Load once per restart request, pulse a self clear, wait for it to drop
	always_comb begin
		rs_d = rs_q;
		active_d = active_q;
		clr_d = 1'b0;
		case (rs_q)
			pan_pkg::RST_IDLE: begin
				if (autoneg_restart_i) begin
					rs_d = pan_pkg::RST_LOAD;
				end
			end
			pan_pkg::RST_LOAD: begin
				active_d = adv_q;
				clr_d = 1'b1;
				rs_d = pan_pkg::RST_DROP;
			end
			pan_pkg::RST_DROP: begin
				// Guards against reloading while the control bit still reads high
				if (!autoneg_restart_i) begin
					rs_d = pan_pkg::RST_IDLE;
				end
			end
			default: begin
				rs_d = pan_pkg::RST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rs_q <= pan_pkg::RST_IDLE;
			active_q <= ADV_RESET;
			clr_q <= 1'b0;
		end else if (clk_en_i) begin
			rs_q <= rs_d;
			active_q <= active_d;
			clr_q <= clr_d;
		end
	end

	assign autoneg_restart_clr_o = clr_q;
	assign adv_active_o = active_q;

	// ---- Partner ability word
	pan_lp_if lp_bus ();

	// A restart discards the old partner page
	assign lp_bus.capture = partner_page_valid_i;
	assign lp_bus.page_word = partner_page_i;
	assign lp_bus.next_page = partner_next_page_i;
	assign lp_bus.clear = clr_q;

	pan_partner_latch u_partner (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.lp(lp_bus.latch)
	);

	assign partner_is_next_page_o = lp_bus.lp_is_next;

	// ---- Read port
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;

	// Unmapped addresses read zero; data stands until the next read
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (mgmt_rd_i) begin
			rvalid_d = 1'b1;
			case (mgmt_addr_i)
				pan_pkg::ADDR_STATUS: rdata_d = status_word;
				pan_pkg::ADDR_ID_HIGH: rdata_d = id_high_word;
				pan_pkg::ADDR_ID_LOW: rdata_d = id_low_word;
				pan_pkg::ADDR_ADV: rdata_d = adv_q;
				pan_pkg::ADDR_PARTNER: rdata_d = lp_bus.lp_word;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
		end else if (clk_en_i) begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign mgmt_rdata_o = rdata_q;
	assign mgmt_rvalid_o = rvalid_q;
endmodule

/* File: testbench/pan_regs_props.sv */
`timescale 1ns/1ps
// Checker on the register block's ports
module pan_regs_props #(
	parameter logic [23:0] ORG_ID = 24'h000000,
	parameter logic [5:0] MODEL_CODE = 6'h00,
	parameter logic [3:0] REV_CODE = 4'h0
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [4:0] mgmt_addr_i,
	input wire logic mgmt_rd_i,
	input wire logic [15:0] mgmt_rdata_o,
	input wire logic mgmt_rvalid_o,
	input wire logic speed_10_i,
	input wire logic jabber_event_i,
	input wire logic autoneg_restart_i,
	input wire logic autoneg_restart_clr_o,
	input wire logic [15:0] adv_active_o,
	input wire logic partner_page_valid_i,
	input wire logic [15:0] partner_page_i,
	input wire logic partner_next_page_i,
	input wire logic partner_is_next_page_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// A read only counts while the enable is high
	wire rd_en = clk_en_i && mgmt_rd_i;
	a_ext_bit_one: assert property (rd_en && mgmt_addr_i == 5'h01
		|=> mgmt_rvalid_o && mgmt_rdata_o[0]) else $error("status bit 0 low");
	a_jabber_sets: assert property (clk_en_i && speed_10_i && jabber_event_i
		##1 rd_en && mgmt_addr_i == 5'h01 |=> mgmt_rdata_o[1]) else $error("jabber lost");
	a_jabber_clears: assert property (rd_en && mgmt_addr_i == 5'h01 && !jabber_event_i
		##1 rd_en && mgmt_addr_i == 5'h01 && !jabber_event_i |=> !mgmt_rdata_o[1])
		else $error("jabber not cleared");
	a_id_high: assert property (rd_en && mgmt_addr_i == 5'h02
		|=> mgmt_rdata_o == ORG_ID[21:6]) else $error("id high wrong");
	a_id_low: assert property (rd_en && mgmt_addr_i == 5'h03
		|=> mgmt_rdata_o == {ORG_ID[5:0], MODEL_CODE, REV_CODE}) else $error("id low wrong");
	a_adv_fixed: assert property (rd_en && mgmt_addr_i == 5'h04
		|=> mgmt_rdata_o[15:14] == 2'h0 && !mgmt_rdata_o[12] && !mgmt_rdata_o[9]
		&& mgmt_rdata_o[4:0] == 5'h01) else $error("fixed adv bits wrong");
	a_unmapped_zero: assert property (rd_en && (mgmt_addr_i == 5'h00 || mgmt_addr_i > 5'h05)
		|=> mgmt_rdata_o == 16'h0000) else $error("unmapped read not zero");
	a_restart_pulse: assert property (clk_en_i && autoneg_restart_i
		&& $past(clk_en_i && !autoneg_restart_i) ##1 clk_en_i ##1 clk_en_i
		|-> autoneg_restart_clr_o ##1 !autoneg_restart_clr_o) else $error("restart clear");
	a_adv_hold: assert property (!autoneg_restart_clr_o |-> $stable(adv_active_o))
		else $error("link word changed without restart");
	a_next_flag: assert property (clk_en_i && partner_page_valid_i
		|=> partner_is_next_page_o == $past(partner_next_page_i)) else $error("next flag");
	a_partner_word: assert property (clk_en_i && partner_page_valid_i
		##1 rd_en && mgmt_addr_i == 5'h05 && !partner_page_valid_i && !autoneg_restart_clr_o
		|=> mgmt_rdata_o == $past(partner_page_i, 2)) else $error("partner word wrong");
	c_restart: cover property (autoneg_restart_clr_o);
	c_jabber: cover property (clk_en_i && speed_10_i && jabber_event_i);
	c_next_page: cover property (partner_page_valid_i && partner_next_page_i);
endmodule
bind pan_regs pan_regs_props #(.ORG_ID(ORG_ID), .MODEL_CODE(MODEL_CODE), .REV_CODE(REV_CODE))
	u_props (.core_clk_i, .rst_b_i, .clk_en_i, .mgmt_addr_i, .mgmt_rd_i, .mgmt_rdata_o,
	.mgmt_rvalid_o, .speed_10_i, .jabber_event_i, .autoneg_restart_i, .autoneg_restart_clr_o,
	.adv_active_o, .partner_page_valid_i, .partner_page_i, .partner_next_page_i,
	.partner_is_next_page_o);

/* File: testbench/pan_link_partner.sv */
`timescale 1ns/1ps
// Far end of the link: hands over one received code word per send request
module pan_link_partner (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic send_i,
	input wire logic [15:0] word_i,
	input wire logic next_i,
	output logic page_valid_o,
	output logic [15:0] page_o,
	output logic next_page_o
);
	// Idle lines toggle so a stale word is never taken for a fresh one
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			page_valid_o <= 1'b0;
			page_o <= 16'h0000;
			next_page_o <= 1'b0;
		end else begin
			page_valid_o <= send_i;
			page_o <= send_i ? word_i : ~page_o;
			next_page_o <= send_i ? next_i : ~next_page_o;
		end
	end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
	localparam logic [23:0] ORG = 24'h5c3a71; // Arbitrary value
	localparam logic [5:0] MDL = 6'h15; // Arbitrary value
	localparam logic [3:0] REV = 4'h9; // Arbitrary value
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic [4:0] mgmt_addr_i = 5'h00;
	logic mgmt_rd_i = 1'b0;
	logic mgmt_wr_i = 1'b0;
	logic [15:0] mgmt_wdata_i = 16'h0000;
	logic speed_10_i = 1'b0;
	logic jabber_event_i = 1'b0;
	logic autoneg_restart_i = 1'b0;
	logic send = 1'b0;
	logic nxt = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] mgmt_rdata_o, adv_active_o, partner_page_i, adv, w, e_now;
	logic mgmt_rvalid_o, autoneg_restart_clr_o, partner_page_valid_i;
	logic partner_next_page_i, partner_is_next_page_o;
	logic [15:0] exp_q[$];
	int num_errors = 0;
	int checks = 0;
	int seed = 29043;
	always #2.5 core_clk_i = ~core_clk_i;
	pan_regs #(.ORG_ID(ORG), .MODEL_CODE(MDL), .REV_CODE(REV)) dut (.core_clk_i, .rst_b_i,
		.clk_en_i, .mgmt_addr_i, .mgmt_rd_i, .mgmt_wr_i, .mgmt_wdata_i, .mgmt_rdata_o,
		.mgmt_rvalid_o, .speed_10_i, .jabber_event_i, .autoneg_restart_i,
		.autoneg_restart_clr_o, .adv_active_o, .partner_page_valid_i, .partner_page_i,
		.partner_next_page_i, .partner_is_next_page_o);
	pan_link_partner lp (.core_clk_i, .rst_b_i, .send_i(send), .word_i(word), .next_i(nxt),
		.page_valid_o(partner_page_valid_i), .page_o(partner_page_i),
		.next_page_o(partner_next_page_i));
	task automatic summarize();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0 && exp_q.size() == 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One bus cycle; a read also notes the word it must return
	task automatic cyc(input logic r, input logic wv, input logic [4:0] a,
		input logic [15:0] d, input logic [15:0] e);
		@(posedge core_clk_i);
		#1;
		mgmt_rd_i = r;
		mgmt_wr_i = wv;
		mgmt_addr_i = a;
		mgmt_wdata_i = d;
		if (r) exp_q.push_back(e);
	endtask
	task automatic rdx(input logic [4:0] a, input logic [15:0] e);
		cyc(1'b1, 1'b0, a, 16'h0000, e);
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b0, 5'h00, 16'h0000, 16'h0000);
	endtask
	function automatic logic [15:0] sts(input logic j);
		return {pan_pkg::STS_ABIL_RESET, 9'h000, j, 1'b1};
	endfunction
	// Each read answer is matched against the oldest note
	// A frozen edge leaves rvalid standing, so only enabled edges count
	logic en_s;
	always @(posedge core_clk_i) begin
		en_s = clk_en_i;
		#2;
		if (en_s === 1'b1 && mgmt_rvalid_o === 1'b1) begin
			e_now = (exp_q.size() > 0) ? exp_q.pop_front() : ~mgmt_rdata_o;
			`CHK(mgmt_rdata_o, e_now)
		end
	end
	// Cuts a hang short
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_b_i = 1'b1;
		rdx(5'h01, sts(1'b0));
		rdx(5'h02, ORG[21:6]);
		rdx(5'h03, {ORG[5:0], MDL, REV});
		rdx(5'h04, 16'h01e1);
		rdx(5'h05, 16'h0000);
		cyc(1'b1, 1'b1, 5'h1f, 16'hffff, 16'h0000);
		cyc(1'b0, 1'b1, 5'h02, 16'hffff, 16'h0000);
		rdx(5'h02, ORG[21:6]);
		// Corner words first, then random ones; only writable bits stick
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
			cyc(1'b0, 1'b1, 5'h04, w, 16'h0000);
			adv = (w & pan_pkg::ADV_WR_MASK) | 16'h0001;
			rdx(5'h04, adv);
		end
		idle(1);
		`CHK(adv_active_o, 16'h01e1)
		// A write while the enable is low is not taken
		clk_en_i = 1'b0;
		cyc(1'b0, 1'b1, 5'h04, 16'h0000, 16'h0000);
		idle(1);
		clk_en_i = 1'b1;
		rdx(5'h04, adv);
		// Jabber is ignored above 10 Mb/s and sticks at 10 Mb/s until read
		jabber_event_i = 1'b1;
		idle(1);
		jabber_event_i = 1'b0;
		rdx(5'h01, sts(1'b0));
		speed_10_i = 1'b1;
		jabber_event_i = 1'b1;
		idle(1);
		jabber_event_i = 1'b0;
		idle(2);
		rdx(5'h01, sts(1'b1));
		rdx(5'h01, sts(1'b0));
		// Base page, then a next page, from the far end
		for (int i = 0; i < 2; i++) begin
			word = (i == 0) ? 16'h65e1 : 16'h9a41;
			nxt = (i == 1);
			send = 1'b1;
			idle(1);
			send = 1'b0;
			rdx(5'h05, word);
			`CHK(partner_is_next_page_o, nxt)
		end
		// Restart puts the stored word on the link and clears the partner word
		autoneg_restart_i = 1'b1;
		for (int i = 0; i < 8; i++) if (autoneg_restart_clr_o !== 1'b1) idle(1);
		`CHK(autoneg_restart_clr_o, 1'b1)
		if (autoneg_restart_clr_o !== 1'b1) summarize();
		`CHK(adv_active_o, adv)
		idle(1);
		`CHK(autoneg_restart_clr_o, 1'b0)
		autoneg_restart_i = 1'b0;
		rdx(5'h05, 16'h0000);
		// Ability bits unmoved by the control-bit traffic; bus is the only access path
		rdx(5'h01, sts(1'b0));
		// Second reset mid-run restores the defaults
		idle(2);
		rst_b_i = 1'b0;
		idle(1);
		rst_b_i = 1'b1;
		rdx(5'h04, 16'h01e1);
		`CHK(adv_active_o, 16'h01e1)
		idle(4);
		summarize();
	end
endmodule
